// ---- core/timer_flag_mirror_fault_mode_regs.sv ----
// Our own choices: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "timer_regs_params.svh"
module timer_flag_mirror_fault_mode_regs (
   // Clock, reset, enable
   input wire logic i_sys_clk,
   input wire logic i_rst,
   input wire logic i_clk_en,
   // Avalon-MM slave
   input wire logic [`ADDR_W-1:0] i_address,
   input wire logic i_read,
   input wire logic i_write,
   input wire logic [31:0] i_writedata,
   input wire logic [3:0] i_byteenable,
   output logic [31:0] o_readdata,
   output logic o_waitrequest,
   // Channel logic
   input wire timer_regs_pkg::chan_vec_type i_chan_event,
   input wire logic i_fault_detected,
   // Fault control logic
   output timer_regs_pkg::chan_vec_type o_fault_chan_enable,
   output logic o_fault_auto_clear,
   output logic o_fault_irq,
   output logic o_write_protect_disable,
   // Interrupt
   output logic o_irq
);
   import timer_regs_pkg::*;

   chan_vec_type channel_event_flag;
   chan_vec_type armed;
   logic fault_irq_enable;
   fault_mode_type fault_control_mode;
   logic write_protect_disable;
   logic write_protect_enable_seen;
   logic [1:0] irq_status;
   logic [1:0] irq_mask;
   logic busy;
   logic fault_sync1, fault_sync2;
   chan_vec_type ev_sync1, ev_sync2;

   logic acc, wr, rd;
   logic hit_flag, hit_mode, hit_write_protect_enable, hit_ists, hit_imask;
   chan_vec_type next_flags;
   chan_vec_type fault_en_comb;
   logic fault_on;
   logic fault_cond;
   logic wr_write_protect_enable_one, wr_write_protect_disable;
   logic [1:0] next_irq_status;
   logic [31:0] next_readdata;

   // Single-cycle wait so each access is answered on the 2nd edge
   assign acc = (i_read | i_write) & i_clk_en;
   assign wr = i_write & busy & i_clk_en;
   assign rd = i_read & busy & i_clk_en;
   assign hit_flag = (i_address == {1'b0, `OFS_FLAG_SUMMARY});
   assign hit_mode = (i_address == {1'b0, `OFS_FEATURE_MODE});
   assign hit_write_protect_enable = (i_address == {1'b0, `OFS_WPROT_ENABLE});
   assign hit_ists = (i_address == {1'b0, `OFS_IRQ_STATUS});
   assign hit_imask = (i_address == `OFS_IRQ_MASK_HI);

   // Protection strobes, qualified by the answer cycle
   assign wr_write_protect_enable_one = wr & hit_write_protect_enable & i_byteenable[0] &
      i_writedata[`WRITE_PROTECT_ENABLE_BIT];
   assign wr_write_protect_disable = wr & hit_mode & i_byteenable[0] &
      i_writedata[`MODE_WRITE_PROTECT_DISABLE_BIT] & write_protect_enable_seen;

   // Fault condition shared by the irq output and the status bit
   assign fault_cond = fault_irq_enable & fault_on & fault_sync2;

   // Channel event pins synchronised before any logic reads them
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         ev_sync1 <= `RST_FLAGS;
         ev_sync2 <= `RST_FLAGS;
      end else if (i_clk_en) begin
         ev_sync1 <= i_chan_event;
         ev_sync2 <= ev_sync1;
      end
   end

   // Fault pin synchronised; adds two cycles of fault latency
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         fault_sync1 <= 1'b0;
         fault_sync2 <= 1'b0;
      end else if (i_clk_en) begin
         fault_sync1 <= i_fault_detected;
         fault_sync2 <= fault_sync1;
      end
   end

   // Busy marks the answer cycle of a taken request
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         busy <= 1'b0;
      end else if (i_clk_en) begin
         busy <= acc & ~busy;
      end
   end

   // Waitrequest low one cycle per access; high while idle
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         o_waitrequest <= 1'b1;
      end else if (i_clk_en) begin
         o_waitrequest <= ~(acc & ~busy);
      end
   end

   // Flag update: event set beats any clear in the same cycle
   always_comb begin
      next_flags = channel_event_flag;
      if (wr && hit_flag && i_byteenable[0]) begin
         // Clear only armed bits written 0; 1 does nothing
         next_flags = channel_event_flag & ~(armed & ~i_writedata[7:0]);
      end
      next_flags = next_flags | ev_sync2;
   end

   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         channel_event_flag <= `RST_FLAGS;
      end else if (i_clk_en) begin
         channel_event_flag <= next_flags;
      end
   end

   // Arming: read while set; a new event disarms the bit
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         armed <= `RST_FLAGS;
      end else if (i_clk_en) begin
         if (rd && hit_flag) begin
            armed <= channel_event_flag & ~ev_sync2;
         end else if (wr && hit_flag && i_byteenable[0]) begin
            armed <= `RST_FLAGS;
         end else begin
            armed <= armed & ~ev_sync2;
         end
      end
   end

   // Feature-mode fields; bits above 7 are not stored
   // Irq enable stays writable while the mode field is protected
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         fault_irq_enable <= `RST_FIE;
         fault_control_mode <= FM_DISABLED;
      end else if (i_clk_en && wr && hit_mode && i_byteenable[0]) begin
         fault_irq_enable <= i_writedata[`MODE_FIE_BIT];
         if (write_protect_disable) begin
            fault_control_mode <= fault_mode_type'(
               i_writedata[`MODE_FM_HI:`MODE_FM_LO]);
         end
      end
   end

   // Write protection: writing 1 to the enable view restores it
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         write_protect_disable <= `RST_WRITE_PROTECT_DISABLE;
      end else if (i_clk_en) begin
         if (wr_write_protect_enable_one) begin
            write_protect_disable <= 1'b0;
         end else if (wr_write_protect_disable) begin
            write_protect_disable <= 1'b1;
         end
      end
   end

   // Enable read as 1 arms the disable write; either write disarms
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         write_protect_enable_seen <= 1'b0;
      end else if (i_clk_en) begin
         if (wr_write_protect_enable_one || wr_write_protect_disable) begin
            write_protect_enable_seen <= 1'b0;
         end else if (rd && hit_write_protect_enable) begin
            write_protect_enable_seen <= ~write_protect_disable;
         end
      end
   end

   // Global mode decoded to per-channel enables, same for whole module
   // All four codes are legal, so no default branch is needed
   always_comb begin
      unique case (fault_control_mode)
         FM_DISABLED: fault_en_comb = 8'h00;
         FM_EVEN_MANUAL: fault_en_comb = 8'h55;
         FM_ALL_MANUAL: fault_en_comb = 8'hFF;
         FM_ALL_AUTO: fault_en_comb = 8'hFF;
      endcase
   end
   assign fault_on = (fault_control_mode != FM_DISABLED);

   // Channel enables toward the fault logic, one pattern for all
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         o_fault_chan_enable <= 8'h00;
      end else if (i_clk_en) begin
         o_fault_chan_enable <= fault_en_comb;
      end
   end

   // Automatic clearing only in the all-channel automatic mode
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         o_fault_auto_clear <= 1'b0;
      end else if (i_clk_en) begin
         o_fault_auto_clear <= (fault_control_mode == FM_ALL_AUTO);
      end
   end

   // Fault irq gated by enable bit and active fault control
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         o_fault_irq <= 1'b0;
      end else if (i_clk_en) begin
         o_fault_irq <= fault_cond;
      end
   end

   // Protection state copy, one cycle behind the register
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         o_write_protect_disable <= 1'b0;
      end else if (i_clk_en) begin
         o_write_protect_disable <= write_protect_disable;
      end
   end

   // Sticky status: a read clears, a set in the same cycle wins
   always_comb begin
      next_irq_status = irq_status;
      if (rd && hit_ists) begin
         next_irq_status = `RST_IRQ;
      end
      next_irq_status = next_irq_status | {fault_cond, |ev_sync2};
   end

   // Interrupt status register
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         irq_status <= `RST_IRQ;
      end else if (i_clk_en) begin
         irq_status <= next_irq_status;
      end
   end

   // Mask register
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         irq_mask <= `RST_IRQ;
      end else if (i_clk_en && wr && hit_imask && i_byteenable[0]) begin
         irq_mask <= i_writedata[1:0];
      end
   end

   // Level interrupt output
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         o_irq <= 1'b0;
      end else if (i_clk_en) begin
         o_irq <= |(irq_status & irq_mask);
      end
   end

   // Read mux; idle cycles and unmapped addresses give zero
   always_comb begin
      next_readdata = 32'h0000_0000;
      if (i_read && !busy) begin
         if (hit_flag) begin
            next_readdata = {24'h000000, channel_event_flag};
         end else if (hit_mode) begin
            next_readdata = {24'h000000, fault_irq_enable,
               fault_control_mode, 2'b00, write_protect_disable,
               2'b00};
         end else if (hit_write_protect_enable) begin
            next_readdata = {31'h0, ~write_protect_disable};
         end else if (hit_ists) begin
            next_readdata = {30'h0, irq_status};
         end else if (hit_imask) begin
            next_readdata = {30'h0, irq_mask};
         end
      end
   end

   // Read data registered so it stands in the answer cycle only
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         o_readdata <= 32'h0000_0000;
      end else if (i_clk_en) begin
         o_readdata <= next_readdata;
      end
   end
endmodule

// ---- core/timer_regs_params.svh ----
`ifndef TIMER_REGS_PARAMS_SVH
`define TIMER_REGS_PARAMS_SVH
// Register byte offsets
`define OFS_FLAG_SUMMARY 4'h0
`define OFS_FEATURE_MODE 4'h4
`define OFS_WPROT_ENABLE 4'h8
`define OFS_IRQ_STATUS 4'hC
`define OFS_IRQ_MASK 4'h0
// Address width in bits; byte addresses, word aligned
`define ADDR_W 5
`define OFS_IRQ_MASK_HI 5'h10
// Feature-mode field positions
`define MODE_FIE_BIT 7
`define MODE_FM_HI 6
`define MODE_FM_LO 5
`define MODE_WRITE_PROTECT_DISABLE_BIT 2
`define WRITE_PROTECT_ENABLE_BIT 0
// Interrupt status positions
`define IRQ_CHAN_BIT 0
`define IRQ_FAULT_BIT 1
// Reset values
`define RST_FLAGS 8'h00
`define RST_FIE 1'h0
`define RST_FM 2'h0
`define RST_WRITE_PROTECT_DISABLE 1'h0
`define RST_IRQ 2'h0
`endif

// ---- core/timer_regs_pkg.sv ----
package timer_regs_pkg;
   typedef enum logic [1:0] {
      FM_DISABLED = 2'b00,
      FM_EVEN_MANUAL = 2'b01,
      FM_ALL_MANUAL = 2'b10,
      FM_ALL_AUTO = 2'b11
   } fault_mode_type;
   typedef logic [7:0] chan_vec_type;
endpackage

// ---- tb/timer_flag_mirror_fault_mode_regs_tb.sv ----
`timescale 1ns/1ps
module timer_flag_mirror_fault_mode_regs_tb;
   import timer_regs_pkg::*;
   // Bench signals
   logic i_sys_clk = 0, i_rst = 1, i_read = 0, i_write = 0, i_clk_en = 1;
   logic i_fault_detected = 0, o_waitrequest, o_fault_auto_clear;
   logic o_fault_irq, o_write_protect_disable, o_irq;
   logic [4:0] i_address = 5'h00;
   logic [31:0] i_writedata = 32'h0, o_readdata, rd;
   chan_vec_type i_chan_event = 8'h00, o_fault_chan_enable;
   chan_vec_type exp_en [4] = '{8'h00, 8'h55, 8'hFF, 8'hFF};
   int bad_count = 0, check_count = 0, m;
   always #12.5 i_sys_clk = ~i_sys_clk;
   // Byte lanes tied: all fields sit in byte 0
   timer_flag_mirror_fault_mode_regs u_timer_flag_mirror_fault_mode_regs (
      .i_sys_clk, .i_rst, .i_clk_en, .i_address, .i_read, .i_write,
      .i_writedata, .i_byteenable(4'hF), .o_readdata, .o_waitrequest,
      .i_chan_event, .i_fault_detected, .o_fault_chan_enable,
      .o_fault_auto_clear, .o_fault_irq, .o_write_protect_disable, .o_irq);
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // One Avalon access, held until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [4:0] a,
                      input logic [31:0] d);
      int n;
      i_address <= a;
      i_writedata <= d;
      i_read <= !wr;
      i_write <= wr;
      for (n = 0; n < 20; n++) begin
         @(posedge i_sys_clk);
         if (o_waitrequest === 1'b0) break;
      end
      if (n < 20) begin
         rd = o_readdata;
         i_read <= 1'b0;
         i_write <= 1'b0;
         @(posedge i_sys_clk);
      end else begin
         bad_count++;
         give_verdict();
      end
   endtask
   task automatic rchk(input logic [4:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      check(rd, e);
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge i_sys_clk);
   endtask
   // Main sequence
   initial begin
      repeat (16) @(posedge i_sys_clk);
      i_rst <= 1'b0;
      tick(1);
      rchk(5'h00, 32'h0);
      rchk(5'h04, 32'h0);
      check(o_fault_chan_enable, 8'h00);
      i_chan_event <= 8'h81;
      tick(2);
      i_chan_event <= 8'h00;
      tick(4);
      rchk(5'h00, 32'h81);
      bus(1'b1, 5'h00, 32'hFFFF_FF81);
      rchk(5'h00, 32'h81);
      // Event slips in between the clearing read and write
      i_chan_event <= 8'h01;
      tick(1);
      i_chan_event <= 8'h00;
      tick(4);
      bus(1'b1, 5'h00, 32'h0);
      rchk(5'h00, 32'h01);
      bus(1'b1, 5'h00, 32'h0);
      rchk(5'h00, 32'h0);
      bus(1'b1, 5'h04, 32'hFFFF_FFE4);
      rchk(5'h04, 32'h80);
      rchk(5'h08, 32'h1);
      bus(1'b1, 5'h04, 32'h84);
      tick(1);
      check(o_write_protect_disable, 1'b1);
      for (m = 0; m < 4; m++) begin
         bus(1'b1, 5'h04, {24'h0, 1'b1, m[1:0], 5'h04});
         tick(2);
         check(o_fault_chan_enable, exp_en[m]);
         check(o_fault_auto_clear, m == 3);
      end
      i_fault_detected <= 1'b1;
      tick(5);
      check(o_fault_irq, 1'b1);
      bus(1'b1, 5'h10, 32'h2);
      tick(2);
      check(o_irq, 1'b1);
      bus(1'b1, 5'h04, 32'h64);
      tick(2);
      check(o_fault_irq, 1'b0);
      bus(1'b1, 5'h04, 32'h84);
      tick(2);
      check(o_fault_irq, 1'b0);
      i_fault_detected <= 1'b0;
      tick(4);
      rchk(5'h0C, 32'h3);
      tick(2);
      check(o_irq, 1'b0);
      bus(1'b1, 5'h08, 32'h1);
      tick(2);
      check(o_write_protect_disable, 1'b0);
      rchk(5'h14, 32'h0);
      // Clock enable low freezes the block: a pulse then is never seen
      i_clk_en <= 1'b0;
      i_chan_event <= 8'h10;
      tick(4);
      i_chan_event <= 8'h00;
      tick(1);
      i_clk_en <= 1'b1;
      tick(4);
      rchk(5'h00, 32'h0);
      give_verdict();
   end
endmodule

// ---- tb/timer_regs_checker.sv ----
`timescale 1ns/1ps
`include "timer_regs_params.svh"
module timer_regs_checker (
   // Clock, reset, bus
   input wire logic i_sys_clk, i_rst, i_clk_en,
   input wire logic [`ADDR_W-1:0] i_address,
   input wire logic i_read, i_write,
   input wire logic [31:0] i_writedata,
   input wire logic [3:0] i_byteenable,
   input wire logic [31:0] o_readdata,
   input wire logic o_waitrequest,
   // Channel and fault side
   input wire timer_regs_pkg::chan_vec_type i_chan_event,
   input wire logic i_fault_detected,
   input wire timer_regs_pkg::chan_vec_type o_fault_chan_enable,
   input wire logic o_fault_auto_clear, o_fault_irq,
   input wire logic o_write_protect_disable, o_irq
);
   import timer_regs_pkg::*;
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_rst);
   // Answer lasts one cycle, data only while answering
   chk_answer_one: assert property (!o_waitrequest |=> o_waitrequest)
      else $error("waitrequest low too long");
   chk_rdata_idle: assert property (o_waitrequest |-> o_readdata == 32'h0)
      else $error("readdata not zero when idle");
   chk_upper_zero: assert property (!o_waitrequest |-> !(|o_readdata[31:8]))
      else $error("upper read bits not zero");
   chk_request_taken: assert property ((i_read || i_write) && o_waitrequest
      |-> ##[1:2] !o_waitrequest) else $error("request not answered");
   // Only the three channel patterns may appear
   chk_mode_chans: assert property (o_fault_chan_enable inside
      {8'h00, 8'h55, 8'hFF}) else $error("bad channel pattern");
   chk_auto_all: assert property (o_fault_auto_clear |->
      o_fault_chan_enable == 8'hFF) else $error("auto clear not all");
   chk_irq_needs_mode: assert property (o_fault_irq |->
      o_fault_chan_enable != 8'h00) else $error("fault irq, mode off");
   // Protected field moves only after protection was lifted
   chk_mode_protect: assert property ($changed(o_fault_chan_enable) |->
      ($past(o_write_protect_disable) || $past(o_write_protect_disable, 2)))
      else $error("mode changed while protected");
   chk_wp_clear: assert property (i_write && !o_waitrequest &&
      i_address == {1'b0, `OFS_WPROT_ENABLE} && i_writedata[0] |-> ##[1:2]
      !o_write_protect_disable) else $error("protect not restored");
   cov_irq: cover property (o_irq);
   cov_even: cover property (o_fault_chan_enable == 8'h55);
   cov_auto: cover property (o_fault_auto_clear);
endmodule
bind timer_flag_mirror_fault_mode_regs timer_regs_checker u_timer_regs_checker (
   .i_sys_clk, .i_rst, .i_clk_en, .i_address, .i_read, .i_write,
   .i_writedata, .i_byteenable, .o_readdata, .o_waitrequest, .i_chan_event,
   .i_fault_detected, .o_fault_chan_enable, .o_fault_auto_clear,
   .o_fault_irq, .o_write_protect_disable, .o_irq);
